// >>> hdl/lsc_integrator.sv
module lsc_integrator (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic run,
  input wire logic gainHigh,
  input wire logic pulse,
  output logic [15:0] result
);
  logic pulsePrev_ff;
  logic [15:0] acc_ff;
  logic [16:0] sum;

  assign sum = {1'b0, acc_ff} + (gainHigh ? {1'b0, lsc_pkg::GAIN_STEP_HI} : 17'h00001);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulsePrev_ff <= 1'b0;
    end else if (ce) begin
      pulsePrev_ff <= pulse;
    end
  end

  // saturate rather than wrap: a bright scene must not read as dark
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= 16'h0000;
    end else if (ce) begin
      if (clear) begin
        acc_ff <= 16'h0000;
      end else if (run && pulse && !pulsePrev_ff) begin
        acc_ff <= sum[16] ? 16'hFFFF : sum[15:0];
      end
    end
  end

  assign result = acc_ff;
endmodule // lsc_integrator

// >>> hdl/lsc_pkg.sv
package lsc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h1;
  localparam logic [3:0] OFF_MASK = 4'h2;
  localparam logic [3:0] OFF_THLO = 4'h3;
  localparam logic [3:0] OFF_THHI = 4'h4;
  localparam logic [3:0] OFF_PERS = 4'h5;
  localparam logic [3:0] OFF_DATA0 = 4'h6;
  localparam logic [3:0] OFF_DATA1 = 4'h7;
  localparam logic [3:0] OFF_INFO = 4'h8;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_PWR = 0;
  localparam int CTRL_ALERT = 1;
  localparam int CTRL_TSEL = 2;
  localparam int CTRL_GAIN = 4;
  localparam int ST_DONE = 0;
  localparam int ST_THR = 1;
  localparam int ST_W = 2;
  localparam int INFO_VAR = 7;
  localparam int INFO_VALID = 8;
  localparam logic [ST_W-1:0] MASK_RST = 2'h0;
  localparam logic [15:0] THLO_RST = 16'h0000;
  localparam logic [15:0] THHI_RST = 16'hFFFF;
  localparam logic [3:0] PERS_RST = 4'h0;
  localparam logic [1:0] TSEL_RST = 2'h2;
  // ****************************************
  // timing in oscillator ticks, high-gain step, bus rates in kHz
  // ****************************************
  localparam logic [11:0] TICKS_SHORT = 12'h040;
  localparam logic [11:0] TICKS_MID = 12'h200;
  localparam logic [11:0] TICKS_LONG = 12'h800;
  localparam logic [15:0] GAIN_STEP_HI = 16'h0010;
  localparam int BUS_KHZ_SMB = 100;
  localparam int BUS_KHZ_I2C = 400;
  // arbitrary slave addresses for the three strap levels
  localparam logic [6:0] SADDR_GND = 7'h11;
  localparam logic [6:0] SADDR_FLT = 7'h12;
  localparam logic [6:0] SADDR_VDD = 7'h13;
  typedef enum logic [1:0] {CV_OFF, CV_INTEG, CV_XFER} lsc_conv_type;
endpackage

// >>> hdl/lsc_sync.sv
module lsc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // lsc_sync

// >>> hdl/lsc_top.sv
// The register addresses and strobed register access were left to the implementer.
module lsc_top #(
  parameter logic SMB_VARIANT = 1'b0,
  parameter logic [6:0] ADDR_GND = lsc_pkg::SADDR_GND,
  parameter logic [6:0] ADDR_FLT = lsc_pkg::SADDR_FLT,
  parameter logic [6:0] ADDR_VDD = lsc_pkg::SADDR_VDD
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [lsc_pkg::AW-1:0] regAddr,
  input wire logic [lsc_pkg::DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [lsc_pkg::DW-1:0] regRdata,
  input wire logic oscIn,
  input wire logic [1:0] pdPulse,
  input wire logic [1:0] adrSel,
  output logic intPinO,
  output logic intPinOe,
  output logic irq,
  output logic [6:0] slaveAddr,
  output logic convActive
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic oscSync;
  logic [1:0] pdSync;
  logic [1:0] adrSync;
  logic oscPrev_ff;
  logic oscTick;

  lsc_sync #(.W(5)) uSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .din({oscIn, pdPulse, adrSel}),
    .dout({oscSync, pdSync, adrSync})
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      oscPrev_ff <= 1'b0;
    end else if (ce) begin
      oscPrev_ff <= oscSync;
    end
  end

  assign oscTick = oscSync && !oscPrev_ff;

  // ****************************************
  // registers
  // ****************************************
  logic pwr_ff;
  logic alertMode_ff;
  logic [1:0] tsel_ff;
  logic gain_ff;
  logic [lsc_pkg::ST_W-1:0] stat_ff;
  logic [lsc_pkg::ST_W-1:0] mask_ff;
  logic [15:0] thLo_ff;
  logic [15:0] thHi_ff;
  logic [3:0] pers_ff;
  logic [15:0] data0_ff;
  logic [15:0] data1_ff;
  logic [15:0] rdata_ff;
  logic wrCtrl;
  logic wrStat;
  logic rdStat;

  assign wrCtrl = regWr && regAddr == lsc_pkg::OFF_CTRL;
  assign wrStat = regWr && regAddr == lsc_pkg::OFF_STAT;
  assign rdStat = regRd && regAddr == lsc_pkg::OFF_STAT;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff <= 1'b0;
      alertMode_ff <= SMB_VARIANT;
      tsel_ff <= lsc_pkg::TSEL_RST;
      gain_ff <= 1'b0;
    end else if (ce && wrCtrl) begin
      pwr_ff <= regWdata[lsc_pkg::CTRL_PWR];
      alertMode_ff <= regWdata[lsc_pkg::CTRL_ALERT];
      tsel_ff <= regWdata[lsc_pkg::CTRL_TSEL +: 2];
      gain_ff <= regWdata[lsc_pkg::CTRL_GAIN];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= lsc_pkg::MASK_RST;
      thLo_ff <= lsc_pkg::THLO_RST;
      thHi_ff <= lsc_pkg::THHI_RST;
      pers_ff <= lsc_pkg::PERS_RST;
    end else if (ce && regWr) begin
      case (regAddr)
        lsc_pkg::OFF_MASK: mask_ff <= regWdata[lsc_pkg::ST_W-1:0];
        lsc_pkg::OFF_THLO: thLo_ff <= regWdata;
        lsc_pkg::OFF_THHI: thHi_ff <= regWdata;
        lsc_pkg::OFF_PERS: pers_ff <= regWdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  lsc_pkg::lsc_conv_type state_ff;
  logic [11:0] tickCnt_ff;
  logic [11:0] tickLimit;
  logic intgRun;
  logic intgClear;
  logic convActive_ff;
  logic [15:0] res [2];

  always_comb begin
    case (tsel_ff)
      2'h0: tickLimit = lsc_pkg::TICKS_SHORT;
      2'h1: tickLimit = lsc_pkg::TICKS_MID;
      default: tickLimit = lsc_pkg::TICKS_LONG;
    endcase
  end

  // one run and one clear feed both channels
  assign intgRun = state_ff == lsc_pkg::CV_INTEG;
  assign intgClear = state_ff != lsc_pkg::CV_INTEG;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= lsc_pkg::CV_OFF;
      convActive_ff <= 1'b0;
    end else if (ce) begin
      convActive_ff <= pwr_ff;
      case (state_ff)
        lsc_pkg::CV_OFF: begin
          if (pwr_ff) begin
            state_ff <= lsc_pkg::CV_INTEG;
          end
        end
        lsc_pkg::CV_INTEG: begin
          // power down abandons the cycle under way
          if (!pwr_ff) begin
            state_ff <= lsc_pkg::CV_OFF;
          end else if (oscTick && tickCnt_ff == tickLimit - 12'h001) begin
            state_ff <= lsc_pkg::CV_XFER;
          end
        end
        lsc_pkg::CV_XFER: begin
          state_ff <= pwr_ff ? lsc_pkg::CV_INTEG : lsc_pkg::CV_OFF;
        end
        default: state_ff <= lsc_pkg::CV_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_ff <= 12'h000;
    end else if (ce) begin
      if (!intgRun) begin
        tickCnt_ff <= 12'h000;
      end else if (oscTick) begin
        tickCnt_ff <= tickCnt_ff + 12'h001;
      end
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : gCh
    lsc_integrator uIntg (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .ce(ce),
      .clear(intgClear),
      .run(intgRun),
      .gainHigh(gain_ff),
      .pulse(pdSync[ch]),
      .result(res[ch])
    );
  end

  // both words move in the same edge, so no read sees a mix
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data0_ff <= 16'h0000;
      data1_ff <= 16'h0000;
    end else if (ce && state_ff == lsc_pkg::CV_XFER) begin
      data0_ff <= res[0];
      data1_ff <= res[1];
    end
  end

  // ****************************************
  // threshold, persistence, interrupt
  // ****************************************
  logic xfer;
  logic outNow;
  logic persistHit;
  logic [3:0] persistCnt_ff;
  logic [lsc_pkg::ST_W-1:0] evt;
  logic [lsc_pkg::ST_W-1:0] nxt_stat;
  logic alertLatch_ff;
  logic nxt_alert;
  logic intOe_ff;

  assign xfer = state_ff == lsc_pkg::CV_XFER;
  assign outNow = res[0] > thHi_ff || res[0] < thLo_ff;
  // persistence n needs n+1 consecutive out-of-range cycles
  assign persistHit = outNow && persistCnt_ff >= pers_ff;
  assign evt = {xfer && persistHit, xfer};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      persistCnt_ff <= 4'h0;
    end else if (ce && xfer) begin
      if (!outNow) begin
        persistCnt_ff <= 4'h0;
      end else if (persistCnt_ff != 4'hF) begin
        persistCnt_ff <= persistCnt_ff + 4'h1;
      end
    end
  end

  // a new event wins over a write-one clear in the same cycle
  assign nxt_stat = (stat_ff & ~(wrStat ? regWdata[lsc_pkg::ST_W-1:0] : '0)) | evt;
  // reading status is taken as the alert response
  assign nxt_alert = |(evt & mask_ff) || (alertLatch_ff && !rdStat);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= '0;
      alertLatch_ff <= 1'b0;
      intOe_ff <= 1'b0;
    end else if (ce) begin
      stat_ff <= nxt_stat;
      alertLatch_ff <= nxt_alert;
      intOe_ff <= alertMode_ff ? nxt_alert : |(nxt_stat & mask_ff);
    end
  end

  // pad only ever sinks; release leaves the line to the pull-up
  logic intO_ff;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intO_ff <= 1'b0;
    end else if (ce) begin
      intO_ff <= 1'b0;
    end
  end

  // ****************************************
  // address strap
  // ****************************************
  // sensed as {pulled-up read, pulled-down read}
  logic [1:0] strapWait_ff;
  logic addrValid_ff;
  logic [6:0] slaveAddr_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapWait_ff <= 2'h0;
      addrValid_ff <= 1'b0;
      slaveAddr_ff <= 7'h00;
    end else if (ce) begin
      if (strapWait_ff != 2'h3) begin
        strapWait_ff <= strapWait_ff + 2'h1;
      end else if (!addrValid_ff) begin
        addrValid_ff <= 1'b1;
        case (adrSync)
          2'b00: slaveAddr_ff <= ADDR_GND;
          2'b11: slaveAddr_ff <= ADDR_VDD;
          default: slaveAddr_ff <= ADDR_FLT;
        endcase
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
    end else if (ce) begin
      rdata_ff <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          lsc_pkg::OFF_CTRL: rdata_ff <= {11'h000, gain_ff, tsel_ff, alertMode_ff, pwr_ff};
          lsc_pkg::OFF_STAT: rdata_ff <= {14'h0000, stat_ff};
          lsc_pkg::OFF_MASK: rdata_ff <= {14'h0000, mask_ff};
          lsc_pkg::OFF_THLO: rdata_ff <= thLo_ff;
          lsc_pkg::OFF_THHI: rdata_ff <= thHi_ff;
          lsc_pkg::OFF_PERS: rdata_ff <= {12'h000, pers_ff};
          lsc_pkg::OFF_DATA0: rdata_ff <= data0_ff;
          lsc_pkg::OFF_DATA1: rdata_ff <= data1_ff;
          lsc_pkg::OFF_INFO: rdata_ff <= {7'h00, addrValid_ff, SMB_VARIANT, slaveAddr_ff};
          default: rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // bus rate the serial front end is built for
  localparam int BUS_KHZ = SMB_VARIANT ? lsc_pkg::BUS_KHZ_SMB : lsc_pkg::BUS_KHZ_I2C;
  assign regRdata = rdata_ff;
  assign intPinO = intO_ff;
  assign intPinOe = intOe_ff;
  assign irq = intOe_ff;
  assign slaveAddr = slaveAddr_ff;
  assign convActive = convActive_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  start_clear_a: assert property (ce && $past(ce) && intgRun && !$past(intgRun)
      |-> res[0] == 16'h0000 && res[1] == 16'h0000)
    else $error("channels did not start together from zero");
  xfer_load_a: assert property (ce && xfer |=> data0_ff == $past(res[0])
      && data1_ff == $past(res[1]))
    else $error("data registers not loaded from both channels");
  data_stable_a: assert property (ce && !xfer |=> $stable(data0_ff) && $stable(data1_ff))
    else $error("data register changed outside transfer");
  auto_restart_a: assert property (ce && xfer && pwr_ff |=> state_ff == lsc_pkg::CV_INTEG)
    else $error("no automatic restart after transfer");
  thr_event_a: assert property (ce && xfer && pers_ff == 4'h0 && res[0] > thHi_ff
      |=> stat_ff[lsc_pkg::ST_THR])
    else $error("threshold crossing not flagged");
  persist_gate_a: assert property (ce && xfer && outNow && persistCnt_ff < pers_ff
      && !stat_ff[lsc_pkg::ST_THR] |=> !stat_ff[lsc_pkg::ST_THR])
    else $error("threshold flagged before persistence reached");
  level_hold_a: assert property (ce && !alertMode_ff && |(stat_ff & mask_ff) && !regWr
      |=> intPinOe)
    else $error("level interrupt dropped without clear");
  alert_clear_a: assert property (ce && alertMode_ff && rdStat && !xfer
      |=> !intPinOe)
    else $error("alert not released by response read");
  open_drain_a: assert property (!intPinO)
    else $error("interrupt pin driven high");
  strap_addr_a: assert property ($rose(addrValid_ff) |-> slaveAddr_ff == ADDR_GND
      || slaveAddr_ff == ADDR_FLT || slaveAddr_ff == ADDR_VDD)
    else $error("slave address not from strap table");
  power_down_a: assert property (ce && !pwr_ff && state_ff != lsc_pkg::CV_XFER
      |=> state_ff == lsc_pkg::CV_OFF)
    else $error("conversion running in power down");
  pers_read_a: assert property (ce && regRd && regAddr == lsc_pkg::OFF_PERS && !$past(regWr)
      |=> regRdata == {12'h000, $past(pers_ff)})
    else $error("persistence readback wrong");

  xfer_seen_c: cover property (ce && xfer ##1 state_ff == lsc_pkg::CV_INTEG);
  thr_seen_c: cover property (ce && evt[lsc_pkg::ST_THR]);
  alert_ack_c: cover property (alertLatch_ff && rdStat ##1 !alertLatch_ff);
endmodule // lsc_top

// >>> tb/lsc_light_model.sv
module lsc_light_model (
  output logic oscIn,
  output logic [1:0] pdPulse
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // free-running oscillator, odd phase offset
  // ****************************************
  initial begin
    oscIn = 1'b0;
    pdPulse = 2'h0;
    #7;
    forever #80 oscIn = ~oscIn;
  end
  // ****************************************
  // light pulses, wide enough for the synchroniser
  // ****************************************
  task automatic burst(input int ch, input int n);
    repeat (n) begin
      #80 pdPulse[ch] = 1'b1;
      #80 pdPulse[ch] = 1'b0;
    end
  endtask
endmodule // lsc_light_model

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, arst_n, ce, regWr, regRd, oscIn, intPinO, intPinOe, irq, convActive;
  logic rdPrev = 1'b0;
  logic [lsc_pkg::AW-1:0] regAddr;
  logic [lsc_pkg::DW-1:0] regWdata, regRdata;
  logic [1:0] pdPulse, adrSel;
  logic [6:0] slaveAddr, expAddr;
  logic [15:0] expQ[$];
  int mismatches, n_checks, k0, k1, waitCnt;
  lsc_top i_lsc_top (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .oscIn(oscIn),
    .pdPulse(pdPulse), .adrSel(adrSel), .intPinO(intPinO), .intPinOe(intPinOe), .irq(irq),
    .slaveAddr(slaveAddr), .convActive(convActive));
  lsc_light_model i_lsc_light_model (.oscIn(oscIn), .pdPulse(pdPulse));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkBit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask
  task automatic waitIrq(input int lim);
    waitCnt = 0;
    // step off the edge first: a clear issued just now is not yet visible
    do begin
      @(negedge core_clk);
      waitCnt++;
    end while (irq !== 1'b1 && waitCnt < lim);
    chkBit("irq raised", 1'b1, irq);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // monitor: read data stands only in the cycle after the strobe
  // ****************************************
  always @(posedge core_clk) rdPrev <= regRd;
  always @(negedge core_clk) begin
    if (rdPrev === 1'b1) chk16("read data", expQ.pop_front(), regRdata);
    chkBit("pin enable", irq, intPinOe);
    chkBit("pin data", 1'b0, intPinO);
  end
  initial begin
    #1000000;
    mismatches++;
    print_verdict;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    k0 = $urandom(32'hC652);
    case ($urandom_range(2))
      0: begin
        adrSel = 2'b00;
        expAddr = lsc_pkg::SADDR_GND;
      end
      1: begin
        adrSel = 2'b11;
        expAddr = lsc_pkg::SADDR_VDD;
      end
      default: begin
        adrSel = 2'b10;
        expAddr = lsc_pkg::SADDR_FLT;
      end
    endcase
    k0 = $urandom_range(20, 1);
    k1 = $urandom_range(20, 1);
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk16("address", {9'h000, expAddr}, {9'h000, slaveAddr});
    rd(lsc_pkg::OFF_INFO, {7'h00, 1'b1, 1'b0, expAddr});
    rd(lsc_pkg::OFF_CTRL, 16'h0008);
    rd(lsc_pkg::OFF_MASK, 16'h0000);
    rd(lsc_pkg::OFF_THLO, 16'h0000);
    rd(lsc_pkg::OFF_THHI, 16'hFFFF);
    rd(lsc_pkg::OFF_PERS, 16'h0000);
    rd(lsc_pkg::OFF_STAT, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(lsc_pkg::OFF_DATA0, 16'($urandom));
    rd(lsc_pkg::OFF_DATA0, 16'h0000);
    // first cycle: both channels counted together
    wr(lsc_pkg::OFF_MASK, 16'h0001);
    wr(lsc_pkg::OFF_CTRL, 16'h0001);
    repeat (2) @(negedge core_clk);
    chkBit("active", 1'b1, convActive);
    fork
      i_lsc_light_model.burst(0, k0);
      i_lsc_light_model.burst(1, k1);
    join
    waitIrq(1000);
    rd(lsc_pkg::OFF_STAT, 16'h0001);
    rd(lsc_pkg::OFF_DATA0, 16'(k0));
    rd(lsc_pkg::OFF_DATA1, 16'(k1));
    chkBit("irq held", 1'b1, irq);
    wr(lsc_pkg::OFF_STAT, 16'h0001);
    @(negedge core_clk);
    chkBit("irq cleared", 1'b0, irq);
    // next cycle runs unprompted and is dark, below the lower limit
    wr(lsc_pkg::OFF_THLO, 16'h0005);
    waitIrq(1000);
    rd(lsc_pkg::OFF_STAT, 16'h0003);
    rd(lsc_pkg::OFF_DATA0, 16'h0000);
    rd(lsc_pkg::OFF_DATA1, 16'h0000);
    wr(lsc_pkg::OFF_THLO, 16'h0000);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    waitIrq(1000);
    rd(lsc_pkg::OFF_STAT, 16'h0001);
    wr(lsc_pkg::OFF_STAT, 16'h0001);
    // persistence one needs two out-of-range results in a row
    wr(lsc_pkg::OFF_PERS, 16'h0001);
    wr(lsc_pkg::OFF_THLO, 16'h0005);
    wr(lsc_pkg::OFF_MASK, 16'h0002);
    waitIrq(1500);
    chkBit("persistence wait", 1'b1, waitCnt > 600);
    rd(lsc_pkg::OFF_STAT, 16'h0003);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    // high gain, mid-length integration, just above the upper limit
    wr(lsc_pkg::OFF_PERS, 16'h0000);
    wr(lsc_pkg::OFF_THLO, 16'h0000);
    wr(lsc_pkg::OFF_THHI, 16'(k0 * 16 - 1));
    wr(lsc_pkg::OFF_MASK, 16'h0001);
    wr(lsc_pkg::OFF_CTRL, 16'h0000);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    wr(lsc_pkg::OFF_CTRL, 16'h0015);
    fork
      i_lsc_light_model.burst(0, k0);
    join_none
    waitIrq(5000);
    chkBit("integration time", 1'b1, waitCnt > 4000 && waitCnt < 4200);
    rd(lsc_pkg::OFF_STAT, 16'h0003);
    rd(lsc_pkg::OFF_DATA0, 16'(k0 * 16));
    // alert style: a status read releases the pin, status stays set
    wr(lsc_pkg::OFF_CTRL, 16'h0000);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    wr(lsc_pkg::OFF_CTRL, 16'h0003);
    waitIrq(1000);
    rd(lsc_pkg::OFF_STAT, 16'h0001);
    @(negedge core_clk);
    chkBit("alert released", 1'b0, irq);
    // reset-default integration length, level style again
    wr(lsc_pkg::OFF_CTRL, 16'h0000);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    wr(lsc_pkg::OFF_CTRL, 16'h0009);
    waitIrq(17000);
    chkBit("long integration", 1'b1, waitCnt > 16300 && waitCnt < 16500);
    rd(lsc_pkg::OFF_STAT, 16'h0001);
    // power down: no further conversions
    wr(lsc_pkg::OFF_CTRL, 16'h0000);
    wr(lsc_pkg::OFF_STAT, 16'h0003);
    @(negedge core_clk);
    chkBit("active", 1'b0, convActive);
    repeat (700) @(negedge core_clk);
    chkBit("irq idle", 1'b0, irq);
    rd(lsc_pkg::OFF_STAT, 16'h0000);
    repeat (2) @(posedge core_clk);
    print_verdict;
  end
endmodule // tb
